// >>> core/tts_ctrl.sv
`timescale 1ns/1ps
// How it works
// - Software sets run bit in most modes; event mode sets it by hardware.
// - Channel 0 trigger input is pin 0, or XOR of pins 0 to 2.
// - Master code 000 pulses output on update request or delayed slave reset.
// - Master code 001 outputs counter enable; delayed unless sync start is on.
// - Code 010 outputs update, 011 capture pulses, 100-111 compare references.
// - DMA source bit picks channel event or update event for channel requests.
// - Polarity bit inverts the external trigger before filtering.
// - External clock mode 1 counts active edges of the prescaled external trigger.
// - External trigger divider passes, or divides by 2, 4 or 8.
// - External trigger filter moves after N equal samples at chosen rate.
// - Sync start uses the trigger input as a common start event.
// - Trigger select picks internal, channel or external trigger source.
// - Clear source bit picks dedicated clear input or filtered external trigger.
// - Slave code 000 counts every timer clock while run bit is set.
// - Codes 001 to 011 decode quadrature inputs with direction.
// - Restart mode reinitializes counter on rising trigger edge.
// - Pause mode counts only while the trigger input is high.
// - Event mode starts counter on rising edge and never stops it.
// - External clock mode 0 counts on rising trigger edges.
// - Enable bits gate DMA and interrupt requests per event.
// - Over-capture flags of channels 0 to 3 clear on writing zero.
// - Trigger flag sets on active edge unless slave is off, on both edges in pause mode.
module tts_ctrl #(
  parameter int PSC_W = 3
) (
  // Clock and reset.
  input  wire logic        i_clk_sys,
  input  wire logic        i_sys_rst,
  // Register port.
  input  wire logic [7:0]  i_reg_addr,
  input  wire logic [15:0] i_reg_wdata,
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  output logic      [15:0] o_reg_rdata,
  // Pins.
  input  wire logic        i_ext_trigger,
  input  wire logic [2:0]  i_ch_pin,
  // Counter core and channels.
  input  wire logic        i_counter_run_bit,
  input  wire logic        i_software_update_request,
  input  wire logic        i_update_event,
  input  wire logic [1:0]  i_clock_division,
  input  wire logic [3:0]  i_cc_event,
  input  wire logic [3:0]  i_overcapture_event,
  input  wire logic [3:0]  i_ch_compare_ref,
  // Trigger sources.
  input  wire logic [2:0]  i_internal_trigger,
  input  wire logic        i_ch0_edge_detect,
  input  wire logic        i_ch0_filtered_input,
  input  wire logic        i_ch1_filtered_input,
  input  wire logic        i_ref_clear_input,
  // Results.
  output logic             o_trigger_output,
  output logic             o_counter_enable_signal,
  output logic             o_count_tick,
  output logic             o_count_down,
  output logic             o_counter_reinit,
  output logic             o_counter_run_set,
  output logic             o_ch0_trigger_input,
  output logic             o_ext_trigger_filtered,
  output logic             o_ref_clear_internal,
  output logic             o_irq,
  output logic [5:0]       o_dma_request
);
  typedef struct packed {
    logic [15:0]      moc;
    logic [15:0]      cfg;
    logic [15:0]      die;
    logic [15:0]      evf;
    logic [15:0]      rdata;
    logic             ext_m;
    logic             ext_s;
    logic [2:0]       pin_m;
    logic [2:0]       pin_s;
    logic [1:0]       dt_cnt;
    logic [4:0]       smp_cnt;
    logic [3:0]       flt_cnt;
    logic             flt_out;
    logic [PSC_W-1:0] psc_cnt;
    logic             ext_q;
    logic             trig_q;
    logic             edge_d;
    logic             ch0_q;
    logic             ch1_q;
    logic             reinit_d;
    logic             en_d;
    logic             en;
    logic             trg_out;
    logic             tick;
    logic             down;
    logic             reinit;
    logic             run_set;
    logic             tin0;
    logic             ref_clr;
    logic             irq;
    logic [5:0]       dma;
  } tts_state_t;

  tts_state_t st_ff;
  tts_state_t nxt_st;

  logic [2:0]  slave_mode;
  logic [2:0]  trig_sel;
  logic [2:0]  master_mode;
  logic [3:0]  flt_code;
  logic [1:0]  ext_div;
  logic        ext_clk1;
  logic        sync_start;
  logic        ext_in;
  logic        dt_tick;
  logic        smp_tick;
  logic        ext_fp;
  logic        ext_rise;
  logic        trig_in;
  logic        trig_rise;
  logic        act_edge;
  logic        en_sig;
  logic        qd_edge;
  logic        qd_down;
  logic        slave_upd;
  logic [15:0] flag_set;

  assign slave_mode  = st_ff.cfg[tts_pkg::CFG_MODE +: 3];
  assign trig_sel    = st_ff.cfg[tts_pkg::CFG_SEL +: 3];
  assign master_mode = st_ff.moc[tts_pkg::MOC_MM +: 3];
  assign flt_code    = st_ff.cfg[tts_pkg::CFG_FLT +: 4];
  assign ext_div     = st_ff.cfg[tts_pkg::CFG_DIV +: 2];
  assign ext_clk1    = st_ff.cfg[tts_pkg::CFG_EC1];
  assign sync_start  = st_ff.cfg[tts_pkg::CFG_SYN];

  assign ext_in = st_ff.ext_s ^ st_ff.cfg[tts_pkg::CFG_POL];

  assign dt_tick  = (st_ff.dt_cnt == 2'h0);
  assign smp_tick = (flt_code >= 4'h1 && flt_code <= 4'h3) ||
                    (dt_tick && st_ff.smp_cnt == tts_pkg::flt_div(flt_code));

  assign ext_fp   = (ext_div == 2'h0) ? st_ff.flt_out : st_ff.psc_cnt[ext_div - 2'h1];
  assign ext_rise = ext_fp & ~st_ff.ext_q;

  always_comb begin
    case (trig_sel)
      tts_pkg::TS_RSV: trig_in = 1'b0;
      tts_pkg::TS_C0E: trig_in = i_ch0_edge_detect;
      tts_pkg::TS_C0F: trig_in = i_ch0_filtered_input;
      tts_pkg::TS_C1F: trig_in = i_ch1_filtered_input;
      tts_pkg::TS_EXT: trig_in = ext_fp;
      default:         trig_in = i_internal_trigger[trig_sel[1:0]];
    endcase
  end

  assign trig_rise = trig_in & ~st_ff.trig_q;
  assign act_edge  = sync_start ? st_ff.edge_d : trig_rise;
  // enable from run bit or pause
  assign en_sig    = i_counter_run_bit | (slave_mode == tts_pkg::SM_PAU && trig_in);
  assign slave_upd = (slave_mode == tts_pkg::SM_RST) && act_edge;

  always_comb begin
    qd_edge = 1'b0;
    qd_down = st_ff.down;
    if ((slave_mode == tts_pkg::SM_QD0 || slave_mode == tts_pkg::SM_QD2) &&
        (i_ch1_filtered_input != st_ff.ch1_q)) begin
      qd_edge = 1'b1;
      qd_down = (i_ch1_filtered_input == i_ch0_filtered_input);
    end
    if ((slave_mode == tts_pkg::SM_QD1 || slave_mode == tts_pkg::SM_QD2) &&
        (i_ch0_filtered_input != st_ff.ch0_q)) begin
      qd_edge = 1'b1;
      qd_down = (i_ch0_filtered_input != i_ch1_filtered_input);
    end
  end

  always_comb begin
    flag_set = 16'h0000;
    flag_set[tts_pkg::EVF_UP] = i_update_event | i_software_update_request | slave_upd;
    flag_set[tts_pkg::EVF_CC +: 4] = i_cc_event;
    flag_set[tts_pkg::EVF_OF +: 4] = i_overcapture_event;
    if (slave_mode == tts_pkg::SM_PAU) begin
      flag_set[tts_pkg::EVF_TRG] = trig_in ^ st_ff.trig_q;
    end else if (slave_mode != tts_pkg::SM_OFF) begin
      flag_set[tts_pkg::EVF_TRG] = act_edge;
    end
  end

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ext_m  = i_ext_trigger;
    nxt_st.ext_s  = st_ff.ext_m;
    nxt_st.pin_m  = i_ch_pin;
    nxt_st.pin_s  = st_ff.pin_m;
    nxt_st.dt_cnt = dt_tick ? tts_pkg::dt_reload(i_clock_division) : st_ff.dt_cnt - 2'h1;
    if (dt_tick) begin
      nxt_st.smp_cnt = (st_ff.smp_cnt >= tts_pkg::flt_div(flt_code)) ? 5'h00
                                                                  : st_ff.smp_cnt + 5'h01;
    end
    if (smp_tick) begin
      if (ext_in == st_ff.flt_out) begin
        nxt_st.flt_cnt = 4'h0;
      end else if (st_ff.flt_cnt + 4'h1 >= tts_pkg::flt_len(flt_code)) begin
        nxt_st.flt_out = ext_in;
        nxt_st.flt_cnt = 4'h0;
        if (ext_in) begin
          nxt_st.psc_cnt = st_ff.psc_cnt + 1'b1;
        end
      end else begin
        nxt_st.flt_cnt = st_ff.flt_cnt + 4'h1;
      end
    end
    nxt_st.ext_q  = ext_fp;
    nxt_st.trig_q = trig_in;
    nxt_st.edge_d = trig_rise;
    nxt_st.ch0_q  = i_ch0_filtered_input;
    nxt_st.ch1_q  = i_ch1_filtered_input;
    nxt_st.en     = en_sig;
    nxt_st.en_d   = st_ff.en;
    nxt_st.tin0 = st_ff.moc[tts_pkg::MOC_TIN] ? ^st_ff.pin_s : st_ff.pin_s[0];
    nxt_st.ref_clr = st_ff.cfg[tts_pkg::CFG_CLR] ? st_ff.flt_out : i_ref_clear_input;
    nxt_st.reinit   = slave_upd;
    nxt_st.reinit_d = st_ff.reinit;
    nxt_st.run_set = (slave_mode == tts_pkg::SM_EVT) && act_edge;
    nxt_st.down    = qd_down;
    case (slave_mode)
      tts_pkg::SM_PAU: nxt_st.tick = i_counter_run_bit & trig_in;
      tts_pkg::SM_EC0: nxt_st.tick = i_counter_run_bit & act_edge;
      tts_pkg::SM_QD0, tts_pkg::SM_QD1, tts_pkg::SM_QD2: begin
        nxt_st.tick = i_counter_run_bit & qd_edge;
      end
      default: nxt_st.tick = i_counter_run_bit;
    endcase
    if (ext_clk1) begin
      nxt_st.tick = i_counter_run_bit & ext_rise &
                    (slave_mode != tts_pkg::SM_PAU || trig_in);
    end
    case (master_mode)
      tts_pkg::MM_RST: nxt_st.trg_out = i_software_update_request | st_ff.reinit_d;
      tts_pkg::MM_EN:  nxt_st.trg_out = sync_start ? en_sig : st_ff.en_d;
      tts_pkg::MM_UPD: nxt_st.trg_out = flag_set[tts_pkg::EVF_UP];
      tts_pkg::MM_CCP: nxt_st.trg_out = |i_cc_event;
      default:         nxt_st.trg_out = i_ch_compare_ref[master_mode[1:0]];
    endcase
    nxt_st.rdata = 16'h0000;
    if (i_reg_rd) begin
      case (i_reg_addr)
        tts_pkg::OFS_MOC: nxt_st.rdata = st_ff.moc;
        tts_pkg::OFS_CFG: nxt_st.rdata = st_ff.cfg;
        tts_pkg::OFS_DIE: nxt_st.rdata = st_ff.die;
        tts_pkg::OFS_EVF: nxt_st.rdata = st_ff.evf;
        default:          nxt_st.rdata = 16'h0000;
      endcase
    end
    nxt_st.evf = st_ff.evf | flag_set;
    if (i_reg_wr) begin
      case (i_reg_addr)
        tts_pkg::OFS_MOC: nxt_st.moc = i_reg_wdata & tts_pkg::MSK_MOC;
        tts_pkg::OFS_CFG: nxt_st.cfg = i_reg_wdata & tts_pkg::MSK_CFG;
        tts_pkg::OFS_DIE: nxt_st.die = i_reg_wdata & tts_pkg::MSK_DIE;
        tts_pkg::OFS_EVF: nxt_st.evf = (st_ff.evf & i_reg_wdata) | flag_set;
        default:          nxt_st.rdata = nxt_st.rdata;
      endcase
    end
    nxt_st.evf = nxt_st.evf & tts_pkg::MSK_EVF;
    nxt_st.irq = |(st_ff.evf & st_ff.die & tts_pkg::MSK_IRQ);
    nxt_st.dma[0] = st_ff.evf[tts_pkg::EVF_UP] & st_ff.die[tts_pkg::DIE_UDMA];
    for (int i = 0; i < 4; i++) begin
      nxt_st.dma[i+1] = st_ff.die[tts_pkg::DIE_CDMA+i] &
                        (st_ff.moc[tts_pkg::MOC_DSEL] ? st_ff.evf[tts_pkg::EVF_UP]
                                                      : st_ff.evf[tts_pkg::EVF_CC+i]);
    end
    nxt_st.dma[5] = st_ff.evf[tts_pkg::EVF_TRG] & st_ff.die[tts_pkg::DIE_TDMA];
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_reg_rdata             = st_ff.rdata;
  assign o_trigger_output        = st_ff.trg_out;
  assign o_counter_enable_signal = st_ff.en;
  assign o_count_tick            = st_ff.tick;
  assign o_count_down            = st_ff.down;
  assign o_counter_reinit        = st_ff.reinit;
  assign o_counter_run_set       = st_ff.run_set;
  assign o_ch0_trigger_input     = st_ff.tin0;
  assign o_ext_trigger_filtered  = st_ff.flt_out;
  assign o_ref_clear_internal    = st_ff.ref_clr;
  assign o_irq                   = st_ff.irq;
  assign o_dma_request           = st_ff.dma;

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);

  sequence restart_seen;
    slave_mode == tts_pkg::SM_RST && !sync_start && trig_rise;
  endsequence

  sequence master_reset_held;
    (master_mode == tts_pkg::MM_RST)[*2];
  endsequence

  tin0_xor_a: assert property (
    st_ff.moc[tts_pkg::MOC_TIN] |=> o_ch0_trigger_input == ^$past(st_ff.pin_s))
    else $error("channel 0 trigger input is not the pin XOR");
  reset_pulse_a: assert property (
    (restart_seen ##1 master_reset_held) |=> o_trigger_output)
    else $error("restart did not reach the trigger output");
  restart_init_a: assert property (
    restart_seen |=> o_counter_reinit && st_ff.evf[tts_pkg::EVF_UP])
    else $error("restart did not reinitialize and flag update");
  enable_out_a: assert property (
    master_mode == tts_pkg::MM_EN && sync_start |=> o_trigger_output == $past(en_sig))
    else $error("enable output is delayed under sync start");
  pause_stop_a: assert property (
    slave_mode == tts_pkg::SM_PAU && !ext_clk1 && !trig_in |=> !o_count_tick)
    else $error("counter ticked while paused");
  event_start_a: assert property (
    slave_mode == tts_pkg::SM_EVT && act_edge |=> o_counter_run_set)
    else $error("event mode did not set the run bit");
  ext_clock0_a: assert property (
    slave_mode == tts_pkg::SM_EC0 && !ext_clk1 && !act_edge |=> !o_count_tick)
    else $error("external clock 0 ticked without an edge");
  filter_two_a: assert property (
    (flt_code == 4'h1 && ext_in != st_ff.flt_out && $stable(ext_in))[*2]
      |=> o_ext_trigger_filtered == $past(ext_in))
    else $error("filter with two samples did not follow");
  over_flag_a: assert property (
    i_overcapture_event[3] |=> st_ff.evf[tts_pkg::EVF_OF+3] ##1
      (st_ff.evf[tts_pkg::EVF_OF+3] || $past(i_reg_wr)))
    else $error("over-capture flag lost");
  pause_flag_a: assert property (
    slave_mode == tts_pkg::SM_PAU && trig_in != st_ff.trig_q |=> st_ff.evf[tts_pkg::EVF_TRG])
    else $error("pause edge did not set the trigger flag");
  dma_gate_a: assert property (
    o_dma_request[1] |-> $past(st_ff.die[tts_pkg::DIE_CDMA]) &&
      $past(st_ff.evf[st_ff.moc[tts_pkg::MOC_DSEL] ? tts_pkg::EVF_UP : tts_pkg::EVF_CC]))
    else $error("channel 0 DMA request without flag and enable");
  clear_src_a: assert property (
    st_ff.cfg[tts_pkg::CFG_CLR] |=> o_ref_clear_internal == $past(st_ff.flt_out))
    else $error("clear source does not follow the filtered trigger");
  sync_delay_a: assert property (
    (slave_mode == tts_pkg::SM_RST && sync_start && trig_rise ##1
      slave_mode == tts_pkg::SM_RST && sync_start) |=> o_counter_reinit)
    else $error("sync start did not delay the restart by one cycle");
endmodule

// >>> core/tts_pkg.sv
package tts_pkg;
  // Register offsets and reset value.
  localparam logic [7:0]  OFS_MOC = 8'h04;
  localparam logic [7:0]  OFS_CFG = 8'h08;
  localparam logic [7:0]  OFS_DIE = 8'h0c;
  localparam logic [7:0]  OFS_EVF = 8'h10;
  localparam logic [15:0] RST_VAL = 16'h0000;
  // Writable and readable bits of each register; flags that can raise the interrupt.
  localparam logic [15:0] MSK_MOC = 16'h00f8;
  localparam logic [15:0] MSK_CFG = 16'hffff;
  localparam logic [15:0] MSK_DIE = 16'h5f5f;
  localparam logic [15:0] MSK_EVF = 16'h1e5f;
  localparam logic [15:0] MSK_IRQ = 16'h005f;
  // Field positions.
  localparam int MOC_TIN = 7;
  localparam int MOC_MM  = 4;
  localparam int MOC_DSEL = 3;
  localparam int CFG_POL = 15;
  localparam int CFG_EC1 = 14;
  localparam int CFG_DIV = 12;
  localparam int CFG_FLT = 8;
  localparam int CFG_SYN = 7;
  localparam int CFG_SEL = 4;
  localparam int CFG_CLR = 3;
  localparam int CFG_MODE = 0;
  localparam int DIE_UDMA = 8;
  localparam int DIE_CDMA = 9;
  localparam int DIE_TDMA = 14;
  localparam int EVF_UP = 0;
  localparam int EVF_CC = 1;
  localparam int EVF_TRG = 6;
  localparam int EVF_OF = 9;
  // Slave controller modes.
  localparam logic [2:0] SM_OFF = 3'h0;
  localparam logic [2:0] SM_QD0 = 3'h1;
  localparam logic [2:0] SM_QD1 = 3'h2;
  localparam logic [2:0] SM_QD2 = 3'h3;
  localparam logic [2:0] SM_RST = 3'h4;
  localparam logic [2:0] SM_PAU = 3'h5;
  localparam logic [2:0] SM_EVT = 3'h6;
  localparam logic [2:0] SM_EC0 = 3'h7;
  // Master output modes; codes 4 to 7 pick a compare reference.
  localparam logic [2:0] MM_RST = 3'h0;
  localparam logic [2:0] MM_EN  = 3'h1;
  localparam logic [2:0] MM_UPD = 3'h2;
  localparam logic [2:0] MM_CCP = 3'h3;
  // Trigger sources.
  localparam logic [2:0] TS_RSV = 3'h3;
  localparam logic [2:0] TS_C0E = 3'h4;
  localparam logic [2:0] TS_C0F = 3'h5;
  localparam logic [2:0] TS_C1F = 3'h6;
  localparam logic [2:0] TS_EXT = 3'h7;

  // Dead-time clock period in timer clocks, minus one, for a clock division code.
  function automatic logic [1:0] dt_reload(input logic [1:0] c);
    case (c)
      2'h1:    dt_reload = 2'h1;
      2'h2:    dt_reload = 2'h3;
      default: dt_reload = 2'h0;
    endcase
  endfunction

  // Number of equal samples before the filter output moves.
  function automatic logic [3:0] flt_len(input logic [3:0] c);
    case (c)
      4'h0:                         flt_len = 4'h1;
      4'h1:                         flt_len = 4'h2;
      4'h2:                         flt_len = 4'h4;
      4'h4, 4'h6, 4'h8, 4'hb, 4'he: flt_len = 4'h6;
      4'ha, 4'hd:                   flt_len = 4'h5;
      default:                      flt_len = 4'h8;
    endcase
  endfunction

  // Sampling divider applied to the dead-time clock, minus one.
  function automatic logic [4:0] flt_div(input logic [3:0] c);
    case (c)
      4'h4, 4'h5:       flt_div = 5'h01;
      4'h6, 4'h7:       flt_div = 5'h03;
      4'h8, 4'h9:       flt_div = 5'h07;
      4'ha, 4'hb, 4'hc: flt_div = 5'h0f;
      4'hd, 4'he, 4'hf: flt_div = 5'h1f;
      default:          flt_div = 5'h00;
    endcase
  endfunction
endpackage

// >>> bench/tts_peer.sv
`timescale 1ns/1ps
// Peer timers drive their trigger outputs from a register, one cycle after the request.
module tts_peer (
  // Clock and reset.
  input  wire logic       i_clk_sys,
  input  wire logic       i_sys_rst,
  // Requested levels.
  input  wire logic [2:0] i_level,
  // Trigger lines into the block.
  output logic      [2:0] o_internal_trigger
);
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      o_internal_trigger <= 3'h0;
    end else begin
      o_internal_trigger <= i_level;
    end
  end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [15:0] rdata;
  logic        ext = 1'b0;
  logic [2:0]  pins = 3'h0;
  logic        run = 1'b0;
  logic        swup = 1'b0;
  logic        upd = 1'b0;
  logic [3:0]  cc = 4'h0;
  logic [3:0]  ovc = 4'h0;
  logic [3:0]  cref = 4'h0;
  logic [2:0]  lvl = 3'h0;
  logic [2:0]  iti;
  logic        rclr = 1'b0;
  logic        c0f = 1'b0;
  logic        c1f = 1'b0;
  logic        trg, en, tick, dn, reinit, rset, c0t, etf, rci, irq;
  logic [5:0]  dma;
  logic [11:0] mon;
  logic [15:0] v;
  int          num_errors = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          ticks = 0;
  int          i;

  always #20 clk = ~clk;
  assign mon = {dn, tick, dma[1], dma[0], irq, trg, reinit, rset, en, c0t, rci, etf};

  tts_peer peer (.i_clk_sys(clk), .i_sys_rst(rst), .i_level(lvl), .o_internal_trigger(iti));

  tts_ctrl #(.PSC_W(3)) uut (
    .i_clk_sys(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wdata),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .i_ext_trigger(ext),
    .i_ch_pin(pins), .i_counter_run_bit(run), .i_software_update_request(swup),
    .i_update_event(upd), .i_clock_division(2'h0), .i_cc_event(cc),
    .i_overcapture_event(ovc), .i_ch_compare_ref(cref), .i_internal_trigger(iti),
    .i_ch0_edge_detect(1'b0), .i_ch0_filtered_input(c0f), .i_ch1_filtered_input(c1f),
    .i_ref_clear_input(rclr), .o_trigger_output(trg), .o_counter_enable_signal(en),
    .o_count_tick(tick), .o_count_down(dn), .o_counter_reinit(reinit),
    .o_counter_run_set(rset), .o_ch0_trigger_input(c0t), .o_ext_trigger_filtered(etf),
    .o_ref_clear_internal(rci), .o_irq(irq), .o_dma_request(dma));

  task results;
    $display("checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (tick === 1'b1) begin
      ticks <= ticks + 1;
    end
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end

  task chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  task rreg(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask

  // Looks at the current cycle and the following ones for one monitored output to go high.
  task seek(input int b, input int n);
    logic hit;
    hit = 1'b0;
    for (int k = 0; k < n; k++) begin
      #1 if (mon[b] === 1'b1) hit = 1'b1;
      @(posedge clk);
    end
    chk({15'h0, hit}, 16'h0001);
  endtask

  // Lets synchroniser and filter settle, then compares one monitored output.
  task look(input int b, input logic e);
    repeat (8) @(posedge clk);
    #1 chk({15'h0, mon[b]}, {15'h0, e});
  endtask

  task pulse_upd;
    @(posedge clk);
    upd <= 1'b1;
    @(posedge clk);
    upd <= 1'b0;
  endtask

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) begin
      rreg(8'h04 + 8'(4 * i), v);
      chk(v, tts_pkg::RST_VAL); // reset values
    end
    wreg(8'h04, 16'hffff);
    rreg(8'h04, v);
    chk(v, 16'h00f8); // control bits
    wreg(8'h0c, 16'hffff);
    rreg(8'h0c, v);
    chk(v, 16'h5f5f); // enable bits
    wreg(8'h0c, 16'h0000);
    wreg(8'h20, 16'hffff);
    rreg(8'h20, v);
    chk(v, 16'h0000); // unmapped address
    wreg(8'h04, 16'h0000);
    pins <= 3'b010;
    look(2, 1'b0); // pin zero
    wreg(8'h04, 16'h0080);
    look(2, 1'b1); // pin exclusive-or
    rclr <= 1'b1;
    wreg(8'h08, 16'h0008);
    look(1, 1'b0); // external source
    ext <= 1'b1;
    look(0, 1'b1); // active high
    look(1, 1'b1); // follows filtered trigger
    wreg(8'h08, 16'h8008);
    look(0, 1'b0); // inverted
    wreg(8'h08, 16'h0000);
    look(1, 1'b1); // dedicated input
    for (i = 4; i < 8; i++) begin
      wreg(8'h04, 16'(i << 4));
      cref <= 4'(1 << (i - 4));
      look(6, 1'b1); // compare reference
      cref <= ~(4'(1 << (i - 4)));
      look(6, 1'b0); // other references
    end
    wreg(8'h04, 16'h0020);
    pulse_upd();
    seek(6, 4); // update code
    wreg(8'h04, 16'h0030);
    cc <= 4'h4;
    @(posedge clk);
    cc <= 4'h0;
    seek(6, 4); // capture pulse
    wreg(8'h04, 16'h0000);
    swup <= 1'b1;
    @(posedge clk);
    swup <= 1'b0;
    seek(6, 3); // software update
    wreg(8'h10, 16'h0000);
    // select changed only with slave off
    wreg(8'h08, 16'h0004);
    lvl <= 3'h1;
    seek(5, 4); // restart pulse
    seek(6, 4); // delayed slave reset
    rreg(8'h10, v);
    chk(v & 16'h0040, 16'h0040); // trigger flag
    wreg(8'h10, 16'h0000);
    rreg(8'h10, v);
    chk(v, 16'h0000); // write zero clears
    lvl <= 3'h0;
    wreg(8'h08, 16'h0000);
    wreg(8'h04, 16'h0010);
    wreg(8'h08, 16'h0084);
    lvl <= 3'h1;
    seek(5, 5); // delayed start edge
    lvl <= 3'h0;
    wreg(8'h08, 16'h0000);
    wreg(8'h08, 16'h0006);
    lvl <= 3'h1;
    seek(4, 5); // event starts
    look(4, 1'b0); // single set pulse
    lvl <= 3'h0;
    wreg(8'h08, 16'h0000);
    wreg(8'h08, 16'h0005);
    lvl <= 3'h1;
    look(3, 1'b1); // high runs
    wreg(8'h10, 16'h0000);
    lvl <= 3'h0;
    look(3, 1'b0); // low stops
    rreg(8'h10, v);
    chk(v & 16'h0040, 16'h0040); // falling edge in pause
    wreg(8'h08, 16'h0000);
    wreg(8'h08, 16'h0007);
    lvl <= 3'h1;
    run <= 1'b1;
    seek(10, 5); // external clock tick
    lvl <= 3'h0;
    run <= 1'b0;
    wreg(8'h08, 16'h0000);
    wreg(8'h08, 16'h0001);
    run <= 1'b1;
    c1f <= 1'b1;
    seek(10, 3); // channel 1 edge counts
    look(11, 1'b0); // unequal levels count up
    c1f <= 1'b0;
    look(11, 1'b1); // equal levels count down
    wreg(8'h08, 16'h0002);
    c1f <= 1'b1;
    look(11, 1'b1); // channel 1 ignored
    c0f <= 1'b1;
    look(11, 1'b0); // channel 0 edge counts up
    wreg(8'h08, 16'h0003);
    c0f <= 1'b0;
    look(11, 1'b1); // both-channel mode, channel 0 edge counts down
    run <= 1'b0;
    c1f <= 1'b0;
    wreg(8'h08, 16'h0000);
    wreg(8'h08, 16'h5100);
    run <= 1'b1;
    v = 16'(ticks);
    ext <= 1'b0;
    look(0, 1'b0); // two-sample filter falls
    ext <= 1'b1;
    look(0, 1'b1); // two-sample filter rises
    ext <= 1'b0;
    look(0, 1'b0); // filter falls again
    ext <= 1'b1;
    look(0, 1'b1); // second active edge
    chk(16'(ticks) - v, 16'h0001); // two edges give one tick
    run <= 1'b0;
    wreg(8'h08, 16'h0000);
    wreg(8'h08, 16'h0036);
    lvl <= 3'h7;
    look(4, 1'b0); // reserved select
    lvl <= 3'h0;
    wreg(8'h08, 16'h0000);
    wreg(8'h10, 16'h0000);
    wreg(8'h0c, 16'h0141);
    look(7, 1'b0); // no flag no request
    pulse_upd();
    seek(7, 4); // update interrupt
    seek(8, 1); // update request
    wreg(8'h10, 16'h0000);
    look(7, 1'b0); // cleared flag
    wreg(8'h0c, 16'h0200);
    wreg(8'h04, 16'h0008);
    pulse_upd();
    seek(9, 4); // update drives channel request
    ovc <= 4'h8;
    @(posedge clk);
    ovc <= 4'h0;
    rreg(8'h10, v);
    chk(v & 16'h1000, 16'h1000); // over-capture set
    wreg(8'h10, 16'hefff);
    rreg(8'h10, v);
    chk(v & 16'h1000, 16'h0000); // cleared by zero
    wreg(8'h04, 16'h0010);
    run <= 1'b1;
    seek(6, 4); // enable output
    results();
  end
endmodule
